// *** verilog/lcm_pkg.sv ***
package lcm_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] LCM_ADDR_MASK = 12'h0602;
	localparam logic [11:0] LCM_ADDR_TRIGGER = 12'h0604;
	localparam logic [11:0] LCM_ADDR_BW_SELECT = 12'h0605;
	localparam logic [11:0] LCM_ADDR_BW_CUSTOM = 12'h0606;
	localparam logic [11:0] LCM_ADDR_INPUT_OPT = 12'h0608;
	localparam logic [11:0] LCM_ADDR_PSL_LO = 12'h0609;
	localparam logic [11:0] LCM_ADDR_PSL_HI = 12'h060A;
	localparam logic [11:0] LCM_ADDR_STATUS = 12'h0618;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int LCM_TRIG_COMMIT_BIT = 0;
	localparam int LCM_TRIG_FETCH_BIT = 1;
	localparam int LCM_EXT_FB_BIT = 0;
	localparam int LCM_EDGE_LSB = 6;
	localparam int LCM_CORNER_MSB = 2;
	localparam int LCM_MASK_MSB = 6;
	// ----------------------------------------------------------------
	// reset values and sizes
	// ----------------------------------------------------------------
	localparam logic [7:0] LCM_RST_MASK = 8'h01;
	localparam logic [7:0] LCM_RST_BYTE = 8'h00;
	localparam logic [15:0] LCM_RST_PSL = 16'h0000;
	localparam int LCM_NUM_LOOPS = 4;
	localparam int LCM_CFG_W = 40;
	localparam int LCM_APPLY_CYCLES = 2;
	// ----------------------------------------------------------------
	// codes
	// ----------------------------------------------------------------
	localparam logic [2:0] LCM_CORNER_CUSTOM = 3'h7;
	localparam logic [2:0] LCM_CORNER_MAX_FIXED = 3'h4;
	typedef enum logic [1:0] {
		LCM_EDGE_RISE = 2'b00,
		LCM_EDGE_FALL = 2'b01,
		LCM_EDGE_LOW_PULSE = 2'b10,
		LCM_EDGE_HIGH_PULSE = 2'b11
	} lcm_edge_type;
	typedef enum logic [1:0] {
		LCM_ST_IDLE = 2'b00,
		LCM_ST_FETCH = 2'b01,
		LCM_ST_COMMIT = 2'b10
	} lcm_state_type;
endpackage

// *** verilog/lcm_loop_store.sv ***
`timescale 1ns/1ps
`default_nettype none
// one loop's configuration store with decoded filter controls
module lcm_loop_store #(
	parameter int CFG_W = 40
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic [CFG_W-1:0] load_data,
	output logic [CFG_W-1:0] cfg,
	output logic [7:0] corner_setting,
	output logic corner_reserved,
	output logic midpoint_align,
	output logic external_feedback_enable
);
	import lcm_pkg::*;
	// ----------------------------------------------------------------
	// stored image: {psl[15:0], options, custom, select}
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg <= '0;
		end else if (load) begin
			cfg <= load_data;
		end
	end
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic [2:0] corner_code;
	logic [1:0] edge_sel;
	assign corner_code = cfg[LCM_CORNER_MSB:0];
	assign edge_sel = cfg[16+LCM_EDGE_LSB +: 2];
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			corner_setting <= 8'h00;
			corner_reserved <= 1'b0;
			midpoint_align <= 1'b0;
			external_feedback_enable <= 1'b0;
		end else begin
			// custom code takes the byte; fixed codes pass as index
			if (corner_code == LCM_CORNER_CUSTOM) begin
				corner_setting <= cfg[15:8];
			end else begin
				corner_setting <= {5'h00, corner_code};
			end
			corner_reserved <= (corner_code > LCM_CORNER_MAX_FIXED) &&
				(corner_code != LCM_CORNER_CUSTOM);
			midpoint_align <= (edge_sel == LCM_EDGE_LOW_PULSE) ||
				(edge_sel == LCM_EDGE_HIGH_PULSE);
			external_feedback_enable <= cfg[16+LCM_EXT_FB_BIT];
		end
	end
endmodule
`default_nettype wire

// *** verilog/lcm_mailbox.sv ***
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module lcm_mailbox #(
	parameter int NUM_LOOPS = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [11:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	output logic busy,
	output logic [NUM_LOOPS*8-1:0] loop_corner,
	output logic [NUM_LOOPS-1:0] loop_corner_reserved,
	output logic [NUM_LOOPS-1:0] loop_midpoint_align,
	output logic [NUM_LOOPS-1:0] loop_external_feedback_enable
);
	import lcm_pkg::*;
	// ----------------------------------------------------------------
	// page registers
	// ----------------------------------------------------------------
	logic [7:0] loop_select_mask;
	logic [7:0] loop_cfg_transfer_trigger;
	logic [7:0] loop_bandwidth_select;
	logic [7:0] loop_bandwidth_custom;
	logic [7:0] loop_input_options;
	logic [15:0] phase_slope_limit;
	lcm_state_type state;
	logic [1:0] apply_count;
	logic [NUM_LOOPS-1:0] store_load;
	logic [LCM_CFG_W-1:0] page_image;
	logic [LCM_CFG_W-1:0] store_cfg [NUM_LOOPS];
	logic [LCM_CFG_W-1:0] fetch_cfg;
	logic fetch_req;
	logic commit_req;
	logic trigger_wr;
	logic [7:0] corner_setting [NUM_LOOPS];
	logic [NUM_LOOPS-1:0] corner_res;
	logic [NUM_LOOPS-1:0] mid_align;
	logic [NUM_LOOPS-1:0] ext_fb;

	assign trigger_wr = wr_stb && (addr == LCM_ADDR_TRIGGER);
	assign fetch_req = trigger_wr && wdata[LCM_TRIG_FETCH_BIT];
	// fetch wins when both bits are written together
	assign commit_req = trigger_wr && wdata[LCM_TRIG_COMMIT_BIT] &&
		!wdata[LCM_TRIG_FETCH_BIT];
	assign page_image = {phase_slope_limit, loop_input_options,
		loop_bandwidth_custom, loop_bandwidth_select};
	// page writes are locked while a transfer runs so the image is stable
	logic page_wr_ok;
	assign page_wr_ok = wr_stb && (state == LCM_ST_IDLE);

	// ----------------------------------------------------------------
	// selection of the fetch source: lowest masked loop
	// ----------------------------------------------------------------
	// with several bits set the lowest loop answers; host should set one
	always_comb begin
		fetch_cfg = '0;
		for (int i = NUM_LOOPS - 1; i >= 0; i--) begin
			if (loop_select_mask[i]) begin
				fetch_cfg = store_cfg[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// transfer sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= LCM_ST_IDLE;
			apply_count <= 2'h0;
		end else begin
			case (state)
			LCM_ST_IDLE: begin
				apply_count <= 2'(LCM_APPLY_CYCLES - 1);
				if (fetch_req) begin
					state <= LCM_ST_FETCH;
				end else if (commit_req) begin
					state <= LCM_ST_COMMIT;
				end
			end
			LCM_ST_FETCH, LCM_ST_COMMIT: begin
				if (apply_count == 2'h0) begin
					state <= LCM_ST_IDLE;
				end else begin
					apply_count <= apply_count - 2'h1;
				end
			end
			default: begin
				state <= LCM_ST_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// trigger register: cleared by hardware at completion
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loop_cfg_transfer_trigger <= 8'h00;
		end else if (state == LCM_ST_IDLE) begin
			if (fetch_req) begin
				loop_cfg_transfer_trigger <= 8'h02;
			end else if (commit_req) begin
				loop_cfg_transfer_trigger <= 8'h01;
			end
		end else if (apply_count == 2'h0) begin
			loop_cfg_transfer_trigger <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// loop stores
	// ----------------------------------------------------------------
	always_comb begin
		store_load = '0;
		if (state == LCM_ST_COMMIT && apply_count == 2'h0) begin
			store_load = loop_select_mask[NUM_LOOPS-1:0];
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_LOOPS; g++) begin : g_loop
			lcm_loop_store #(
				.CFG_W(LCM_CFG_W)
			) u_store (
				.clk(clk),
				.rst_b(rst_b),
				.load(store_load[g]),
				.load_data(page_image),
				.cfg(store_cfg[g]),
				.corner_setting(corner_setting[g]),
				.corner_reserved(corner_res[g]),
				.midpoint_align(mid_align[g]),
				.external_feedback_enable(ext_fb[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// page registers, host writes and fetch load
	// ----------------------------------------------------------------
	logic fetch_done;
	assign fetch_done = (state == LCM_ST_FETCH) && (apply_count == 2'h0);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loop_select_mask <= LCM_RST_MASK;
		end else if (page_wr_ok && addr == LCM_ADDR_MASK) begin
			loop_select_mask <= {1'b0, wdata[LCM_MASK_MSB:0]};
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loop_bandwidth_select <= LCM_RST_BYTE;
			loop_bandwidth_custom <= LCM_RST_BYTE;
			loop_input_options <= LCM_RST_BYTE;
			phase_slope_limit <= LCM_RST_PSL;
		end else if (fetch_done) begin
			loop_bandwidth_select <= fetch_cfg[7:0];
			loop_bandwidth_custom <= fetch_cfg[15:8];
			loop_input_options <= fetch_cfg[23:16];
			phase_slope_limit <= fetch_cfg[39:24];
		end else if (page_wr_ok) begin
			case (addr)
			LCM_ADDR_BW_SELECT: begin
				loop_bandwidth_select <= {5'h00,
					wdata[LCM_CORNER_MSB:0]};
			end
			LCM_ADDR_BW_CUSTOM: begin
				loop_bandwidth_custom <= wdata;
			end
			LCM_ADDR_INPUT_OPT: begin
				loop_input_options <= {wdata[LCM_EDGE_LSB +: 2], 5'h00,
					wdata[LCM_EXT_FB_BIT]};
			end
			LCM_ADDR_PSL_LO: begin
				phase_slope_limit[7:0] <= wdata;
			end
			LCM_ADDR_PSL_HI: begin
				phase_slope_limit[15:8] <= wdata;
			end
			default: begin
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	logic [7:0] next_rdata;
	always_comb begin
		case (addr)
		LCM_ADDR_MASK: next_rdata = loop_select_mask;
		LCM_ADDR_TRIGGER: next_rdata = loop_cfg_transfer_trigger;
		LCM_ADDR_BW_SELECT: next_rdata = loop_bandwidth_select;
		LCM_ADDR_BW_CUSTOM: next_rdata = loop_bandwidth_custom;
		LCM_ADDR_INPUT_OPT: next_rdata = loop_input_options;
		LCM_ADDR_PSL_LO: next_rdata = phase_slope_limit[7:0];
		LCM_ADDR_PSL_HI: next_rdata = phase_slope_limit[15:8];
		LCM_ADDR_STATUS: next_rdata = {6'h00, state};
		default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 8'h00;
		end else if (rd_stb) begin
			rdata <= next_rdata;
		end else begin
			rdata <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// registered loop outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
			loop_corner <= '0;
			loop_corner_reserved <= '0;
			loop_midpoint_align <= '0;
			loop_external_feedback_enable <= '0;
		end else begin
			busy <= (state != LCM_ST_IDLE) || fetch_req || commit_req;
			for (int i = 0; i < NUM_LOOPS; i++) begin
				loop_corner[i*8 +: 8] <= corner_setting[i];
			end
			loop_corner_reserved <= corner_res;
			loop_midpoint_align <= mid_align;
			loop_external_feedback_enable <= ext_fb;
		end
	end
endmodule
`default_nettype wire

// *** testbench/lcm_mailbox_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcm_mailbox_sva
	import lcm_pkg::*;
#(
	parameter int NUM_LOOPS = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [11:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [7:0] rdata,
	input wire logic busy,
	input wire logic [NUM_LOOPS*8-1:0] loop_corner,
	input wire logic [NUM_LOOPS-1:0] loop_corner_reserved
);
	// ----------------------------------------------------------------
	// transfer, read-port and decode checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_trig_req;
		wr_stb && addr == LCM_ADDR_TRIGGER && wdata[1:0] != 2'b00 && !busy;
	endsequence
	sequence s_fetch_req;
		s_trig_req ##0 wdata[1];
	endsequence
	property p_busy_start; s_trig_req |=> busy; endproperty
	a_busy_start: assert property (p_busy_start) else $error("no busy");
	// a fresh trigger taken on the last busy cycle keeps busy up
	property p_busy_len;
		$rose(busy) |-> busy[*3] ##1
			(!busy || $past(wr_stb && addr == LCM_ADDR_TRIGGER));
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length");
	property p_idle_read;
		rd_stb && addr == LCM_ADDR_TRIGGER && !busy |=> rdata == 8'h00;
	endproperty
	a_idle_read: assert property (p_idle_read) else $error("trig busy");
	property p_rdata_rest; !$past(rd_stb) |-> rdata == 8'h00; endproperty
	a_rdata_rest: assert property (p_rdata_rest) else $error("rdata");
	// loop_corner may move only just after a transfer ends
	property p_update;
		$changed(loop_corner) |-> $past(busy, 2) || $past(busy, 3);
	endproperty
	a_update: assert property (p_update) else $error("loop change");
	property p_fetch_keeps;
		s_fetch_req ##0 !$past(busy) |=> ($stable(loop_corner))[*5];
	endproperty
	a_fetch_keeps: assert property (p_fetch_keeps) else $error("fetch");
	property p_reserved;
		loop_corner_reserved[1] |-> loop_corner[15:8] inside {8'h05, 8'h06};
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved");
	property p_bw_read;
		rd_stb && addr == LCM_ADDR_BW_SELECT |=> rdata[7:3] == 5'h00;
	endproperty
	a_bw_read: assert property (p_bw_read) else $error("bw bits");
endmodule
bind lcm_mailbox lcm_mailbox_sva #(.NUM_LOOPS(NUM_LOOPS)) lcm_mailbox_sva_inst (
	.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
	.rd_stb(rd_stb), .rdata(rdata), .busy(busy), .loop_corner(loop_corner),
	.loop_corner_reserved(loop_corner_reserved));
`default_nettype wire

// *** testbench/test_lcm_mailbox.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_loop_config_mailbox;
	import lcm_pkg::*;
	logic clk = 0, rst_b = 0, wr_stb = 0, rd_stb = 0, busy;
	logic [11:0] addr = 0;
	logic [7:0] wdata = 0, rdata;
	logic [31:0] corner;
	logic [3:0] res, mid, efb;
	int mismatches = 0, checks = 0;
	lcm_mailbox lcm_mailbox_inst (.clk(clk), .rst_b(rst_b), .addr(addr),
		.wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.busy(busy), .loop_corner(corner), .loop_corner_reserved(res),
		.loop_midpoint_align(mid), .loop_external_feedback_enable(efb));
	initial forever #20 clk = ~clk;
	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1;
		@(posedge clk);
		wr_stb <= 0;
	endtask
	task rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1;
		@(posedge clk);
		rd_stb <= 0;
		#1 d = rdata;
	endtask
	task rdchk(input logic [11:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk(v, e);
	endtask
	// bounded poll so a stuck trigger cannot hang the run
	task run(input logic [7:0] trig);
		logic [7:0] v;
		wr(LCM_ADDR_TRIGGER, trig);
		v = 8'hff;
		for (int n = 0; n < 20 && v !== 8'h00; n++) rd(LCM_ADDR_TRIGGER, v);
		chk(v, 8'h00);
		repeat (3) @(posedge clk);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task test_reset;
		wr(LCM_ADDR_MASK, 8'h04);
		wr(LCM_ADDR_PSL_LO, 8'h34);
		wr(LCM_ADDR_PSL_HI, 8'h12);
		rdchk(LCM_ADDR_PSL_LO, 8'h34);
		rdchk(LCM_ADDR_PSL_HI, 8'h12);
		rdchk(LCM_ADDR_MASK, 8'h04);
		// second reset mid-run: all registers back to reset values
		@(posedge clk);
		rst_b <= 0;
		repeat (2) @(posedge clk);
		rst_b <= 1;
		rdchk(LCM_ADDR_PSL_HI, 8'h00);
		rdchk(LCM_ADDR_STATUS, 8'h00);
		rdchk(LCM_ADDR_TRIGGER, 8'h00);
		rdchk(LCM_ADDR_BW_SELECT, 8'h00);
		rdchk(LCM_ADDR_BW_CUSTOM, 8'h00);
		rdchk(LCM_ADDR_INPUT_OPT, 8'h00);
		rdchk(LCM_ADDR_PSL_LO, 8'h00);
		rdchk(LCM_ADDR_MASK, 8'h01);
		wr(12'h0607, 8'h55);
		rdchk(12'h0607, 8'h00);
		$display("test reset done");
	endtask
	task test_codes;
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			wr(LCM_ADDR_MASK, 8'h02);
			wr(LCM_ADDR_BW_SELECT, {5'h1f, c});
			rdchk(LCM_ADDR_BW_SELECT, {5'h00, c});
			wr(LCM_ADDR_BW_CUSTOM, 8'hC8);
			wr(LCM_ADDR_INPUT_OPT, {c[1:0], 5'h00, c[0]});
			run(8'h01);
			chk(corner[15:8], (c == 3'h7) ? 8'hC8 : {5'h00, c});
			chk(res[1], c == 3'h5 || c == 3'h6);
			chk(mid[1], c[1]);
			chk(efb[1], c[0]);
		end
		$display("test codes done");
	endtask
	task test_multi;
		wr(LCM_ADDR_BW_SELECT, 8'h03);
		wr(LCM_ADDR_INPUT_OPT, 8'h00);
		wr(LCM_ADDR_MASK, 8'h09);
		run(8'h01);
		chk(corner, 32'h0300_C803);
		$display("test multi done");
	endtask
	// both bits set: fetch wins, loops untouched
	task test_fetch;
		wr(LCM_ADDR_BW_CUSTOM, 8'h00);
		wr(LCM_ADDR_INPUT_OPT, 8'h00);
		wr(LCM_ADDR_MASK, 8'h02);
		run(8'h03);
		rdchk(LCM_ADDR_BW_SELECT, 8'h07);
		rdchk(LCM_ADDR_BW_CUSTOM, 8'hC8);
		rdchk(LCM_ADDR_INPUT_OPT, 8'hC1);
		chk(corner, 32'h0300_C803);
		$display("test fetch done");
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1;
		test_reset;
		test_codes;
		test_multi;
		test_fetch;
		end_of_test;
	end
	initial begin
		#400000;
		mismatches++;
		end_of_test;
	end
endmodule
`default_nettype wire
